// >>> design/etcc_pkg.sv
// shared constants for the event timer with capture/compare channels
package etcc_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_COUNT = 8'h00;
    localparam logic [7:0] OFS_CTRL  = 8'h04;
    localparam logic [7:0] OFS_MODE  = 8'h08;
    localparam logic [7:0] OFS_EDGE  = 8'h0c;
    localparam logic [7:0] OFS_CC0   = 8'h10;
    localparam logic [7:0] OFS_CC3   = 8'h1c;
    // ------------------------------------------------------------------
    // timer_control_one fields
    // ------------------------------------------------------------------
    localparam int CTRL_CE    = 0;
    localparam int CTRL_EXT   = 1;
    localparam int CTRL_PRE1  = 2;
    localparam int CTRL_PRE2  = 3;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    // ------------------------------------------------------------------
    // timer_unit_mode fields
    // ------------------------------------------------------------------
    localparam int MODE_OST   = 13;
    localparam int MODE_ECLR  = 12;
    localparam int MODE_TES   = 10;
    localparam int MODE_CES   = 8;
    localparam int MODE_CMS   = 4;
    localparam int MODE_IMS   = 0;
    localparam logic [15:0] MODE_RESET = 16'h0a00;
    localparam logic [15:0] MODE_WMASK = 16'h3fff;
    localparam logic [7:0]  EDGE_RESET = 8'h00;
    // ------------------------------------------------------------------
    // edge selection codes
    // ------------------------------------------------------------------
    localparam logic [1:0] EDG_FALL = 2'h0;
    localparam logic [1:0] EDG_RISE = 2'h1;
    localparam logic [1:0] EDG_NONE = 2'h2;
    localparam logic [1:0] EDG_BOTH = 2'h3;
    // ------------------------------------------------------------------
    // widths and prescaler
    // ------------------------------------------------------------------
    localparam int CNT_W   = 16;
    localparam int NUM_CH  = 4;
    localparam int PRE_W   = 6;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : etcc_pkg

// >>> design/etcc_edge_sync.sv
// two-flop synchroniser with rise and fall detection per input
`timescale 1ns/10ps
module etcc_edge_sync #(
    parameter int W = 6
) (
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } etcc_sync_t;

    etcc_sync_t st;
    etcc_sync_t next_st;

    // ------------------------------------------------------------------
    // s1 feeds s2 only; edges seen between s2 and s3
    // ------------------------------------------------------------------
    always_comb
    begin
        next_st    = st;
        next_st.s1 = pin_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rise = st.s2 & ~st.s3;
    assign fall = ~st.s2 & st.s3;
endmodule : etcc_edge_sync

// >>> design/etcc_prescale.sv
// two-stage prescaler giving six count rates from the bus clock
`timescale 1ns/10ps
module etcc_prescale (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       clr,
    input  wire logic       pre1,
    input  wire logic [1:0] pre2,
    output logic            tick
);
    typedef struct packed {
        logic [etcc_pkg::PRE_W-1:0] cnt;
        logic                       tick;
    } etcc_pre_t;

    etcc_pre_t st;
    etcc_pre_t next_st;

    // ------------------------------------------------------------------
    // mask of 2^(1+pre1+2*pre2) - 1; code 3 of pre2 acts as code 2
    // ------------------------------------------------------------------
    function automatic logic [etcc_pkg::PRE_W-1:0] div_mask(input logic p1,
                                                            input logic [1:0] p2);
        logic [2:0] sh;
        sh = 3'h1 + {2'h0, p1} + ((p2 == 2'h0) ? 3'h0 : (p2 == 2'h1) ? 3'h2 : 3'h4);
        div_mask = ~({etcc_pkg::PRE_W{1'b1}} << sh);
    endfunction : div_mask

    always_comb
    begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (clr)
        begin
            next_st.cnt = '0;
        end
        else
        begin
            next_st.cnt  = st.cnt + 6'h01;
            next_st.tick = ((st.cnt & div_mask(pre1, pre2)) == div_mask(pre1, pre2));
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule : etcc_prescale

// >>> design/etcc_timer.sv
// 16-bit event timer with four capture/compare channels on ahb-lite
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module etcc_timer (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        event_count_input,
    input  wire logic        external_clear_input,
    input  wire logic [3:0]  capture_trigger_input,
    output logic             overflow_irq,
    output logic      [3:0]  channel_match_irq,
    output logic             pulse_out_a,
    output logic             pulse_out_b
);
    typedef struct packed {
        logic [15:0]      count;
        logic [4:0]       ctrl;
        logic [15:0]      mode;
        logic [7:0]       edge_sel;
        logic [3:0][15:0] cc;
        logic             stopped;
        logic             ovf;
        logic [3:0]       ch_irq;
        logic             pa;
        logic             pb;
        logic             wr_pend;
        logic [7:0]       wr_addr;
        logic [31:0]      rdata;
    } etcc_state_t;

    etcc_state_t st;
    etcc_state_t next_st;

    logic [5:0] rise;
    logic [5:0] fall;
    logic       pre_tick;
    logic       pre_clr;
    logic       tick;
    logic       clr_trig;
    logic [3:0] cap_edge;
    logic       running;
    logic       addr_ok;

    // ------------------------------------------------------------------
    // edge selection shared by event, clear and capture inputs
    // ------------------------------------------------------------------
    function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
        edge_hit = ((sel == etcc_pkg::EDG_RISE) && r) || ((sel == etcc_pkg::EDG_FALL) && f)
                   || ((sel == etcc_pkg::EDG_BOTH) && (r || f));
    endfunction : edge_hit

    // ------------------------------------------------------------------
    // input synchronisers and prescaler
    // ------------------------------------------------------------------
    etcc_edge_sync #(
        .W (6)
    ) u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pin_in   ({capture_trigger_input, external_clear_input, event_count_input}),
        .rise     (rise),
        .fall     (fall)
    );

    etcc_prescale u_pre (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clr      (pre_clr),
        .pre1     (st.ctrl[etcc_pkg::CTRL_PRE1]),
        .pre2     (st.ctrl[etcc_pkg::CTRL_PRE2 +: 2]),
        .tick     (pre_tick)
    );

    // ------------------------------------------------------------------
    // count source and triggers
    // ------------------------------------------------------------------
    always_comb
    begin
        clr_trig = st.mode[etcc_pkg::MODE_ECLR]
                   && edge_hit(st.mode[etcc_pkg::MODE_CES +: 2], rise[1], fall[1]);
        running  = st.ctrl[etcc_pkg::CTRL_CE] && !st.stopped;
        pre_clr  = clr_trig || !running;
        if (st.ctrl[etcc_pkg::CTRL_EXT])
        begin
            tick = running && edge_hit(st.mode[etcc_pkg::MODE_TES +: 2], rise[0], fall[0]);
        end
        else
        begin
            tick = running && pre_tick;
        end
        for (int i = 0; i < etcc_pkg::NUM_CH; i++)
        begin
            cap_edge[i] = edge_hit(st.edge_sel[2*i +: 2], rise[2+i], fall[2+i]);
        end
        addr_ok = hsel && htrans[1] && hready;
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [15:0] cnt_nxt;
        logic [7:0]  a;
        logic        wr_cc;
        cnt_nxt          = st.count;
        a                = haddr[7:0];
        wr_cc            = 1'b0;
        next_st          = st;
        next_st.ovf      = 1'b0;
        next_st.ch_irq   = '0;
        next_st.wr_pend  = 1'b0;
        // count update
        if (clr_trig)
        begin
            cnt_nxt                          = '0;
            next_st.stopped                  = 1'b0;
            next_st.ctrl[etcc_pkg::CTRL_CE]  = 1'b1;
        end
        else if (tick)
        begin
            cnt_nxt = st.count + 16'h0001;
            if (st.count == etcc_pkg::CNT_MAX)
            begin
                next_st.ovf     = 1'b1;
                next_st.stopped = st.mode[etcc_pkg::MODE_OST];
            end
        end
        next_st.count = cnt_nxt;
        // channels: capture or compare
        for (int i = 0; i < etcc_pkg::NUM_CH; i++)
        begin
            wr_cc = st.wr_pend && (st.wr_addr == etcc_pkg::OFS_CC0 + 8'(4 * i));
            if (!st.mode[etcc_pkg::MODE_CMS + i])
            begin
                next_st.ch_irq[i] = cap_edge[i];
                if (cap_edge[i] && !wr_cc)
                begin
                    next_st.cc[i] = st.count;
                end
            end
            else if (st.mode[etcc_pkg::MODE_IMS + i])
            begin
                next_st.ch_irq[i] = cap_edge[i];
            end
            else
            begin
                next_st.ch_irq[i] = tick && (cnt_nxt == st.cc[i]);
            end
            if (wr_cc)
            begin
                next_st.cc[i] = hwdata[15:0];
            end
        end
        // set/reset pulse outputs on compare match
        for (int i = 0; i < etcc_pkg::NUM_CH; i++)
        begin
            if (st.mode[etcc_pkg::MODE_CMS + i] && tick && (cnt_nxt == st.cc[i]))
            begin
                if (i < 2)
                begin
                    next_st.pa = (i == 0);
                end
                else
                begin
                    next_st.pb = (i == 2);
                end
            end
        end
        // register writes in the data phase
        if (st.wr_pend)
        begin
            unique case (st.wr_addr)
                etcc_pkg::OFS_CTRL:
                begin
                    next_st.ctrl = hwdata[4:0];
                    if (hwdata[etcc_pkg::CTRL_CE] && !next_st.ovf)
                    begin
                        next_st.stopped = 1'b0;
                    end
                end
                etcc_pkg::OFS_MODE:
                begin
                    next_st.mode = hwdata[15:0] & etcc_pkg::MODE_WMASK;
                end
                etcc_pkg::OFS_EDGE:
                begin
                    next_st.edge_sel = hwdata[7:0];
                end
                default:
                begin
                end
            endcase
        end
        // address phase: latch writes, prepare read data
        if (addr_ok)
        begin
            next_st.wr_pend = hwrite;
            next_st.wr_addr = a;
            next_st.rdata   = '0;
            if (!hwrite)
            begin
                unique case (a)
                    etcc_pkg::OFS_COUNT:
                    begin
                        if (hsize >= 3'h1)
                        begin
                            next_st.rdata = {16'h0000, st.count};
                        end
                    end
                    etcc_pkg::OFS_CTRL:  next_st.rdata = {27'h0, st.ctrl};
                    etcc_pkg::OFS_MODE:  next_st.rdata = {16'h0, st.mode};
                    etcc_pkg::OFS_EDGE:  next_st.rdata = {24'h0, st.edge_sel};
                    default:
                    begin
                        if (a >= etcc_pkg::OFS_CC0 && a <= etcc_pkg::OFS_CC3 && a[1:0] == 2'h0)
                        begin
                            next_st.rdata = {16'h0, st.cc[a[3:2]]};
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st          <= '0;
            st.ctrl     <= etcc_pkg::CTRL_RESET;
            st.mode     <= etcc_pkg::MODE_RESET;
            st.edge_sel <= etcc_pkg::EDGE_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs from flops; hreadyout tied to 1 and hresp tied to 0
    // ------------------------------------------------------------------
    assign hrdata            = st.rdata;
    assign hreadyout         = 1'b1 | st.wr_pend;
    assign hresp             = 1'b0 & st.wr_pend;
    assign overflow_irq      = st.ovf;
    assign channel_match_irq = st.ch_irq;
    assign pulse_out_a       = st.pa;
    assign pulse_out_b       = st.pb;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_count_wraps: assert property (tick && !clr_trig && st.count == 16'hffff
        |=> overflow_irq && st.count == 16'h0000) else $error("no wrap at overflow");
    a_ovf_cause: assert property (overflow_irq
        |-> $past(tick) && $past(st.count) == 16'hffff) else $error("spurious overflow");
    a_stop_holds: assert property (overflow_irq && st.mode[13] && !clr_trig && !st.wr_pend
        |-> st.stopped && st.ctrl[0] ##1 st.count == 16'h0000) else $error("stop failed");
    a_no_count_off: assert property (!st.ctrl[0] && !clr_trig |=> $stable(st.count))
        else $error("counted while off");
    a_clear_start: assert property (clr_trig |=> st.count == 16'h0000 && st.ctrl[0])
        else $error("clear trigger ignored");
    a_pre_reset: assert property (clr_trig && !st.ctrl[1] |=> !tick ##1 !tick)
        else $error("prescaler not cleared");
    a_ext_edge: assert property (st.ctrl[1] && running && st.mode[11:10] == 2'h1 && rise[0]
        && !clr_trig |=> st.count == $past(st.count) + 16'h0001) else $error("event lost");
    a_cap_latch: assert property (!st.mode[4] && cap_edge[0] && !st.wr_pend
        |=> st.cc[0] == $past(st.count) && channel_match_irq[0]) else $error("capture");
    a_write_wins: assert property (st.wr_pend && st.wr_addr == 8'h10
        |=> st.cc[0] == $past(hwdata[15:0])) else $error("write lost");
    a_pulse_set: assert property (st.mode[4] && tick && next_st.count == st.cc[0]
        && !(st.mode[5] && next_st.count == st.cc[1]) |=> pulse_out_a)
        else $error("pulse a not set");
    a_match_irq: assert property (st.mode[4] && !st.mode[0] && tick
        && next_st.count == st.cc[0] |=> channel_match_irq[0]) else $error("no match irq");
    a_div_two: assert property (!st.ctrl[1] && running && st.ctrl[4:2] == 3'h0
        && pre_tick && !pre_clr |=> !pre_tick ##1 (pre_tick || $past(pre_clr)))
        else $error("wrong rate");

    c_overflow: cover property (overflow_irq);
    c_capture: cover property (!st.mode[4] && channel_match_irq[0]);
    c_compare_pulse: cover property (pulse_out_a ##[1:100] !pulse_out_a);
    c_ext_clear: cover property (clr_trig && st.stopped);
    c_pin_irq: cover property (st.mode[7] && st.mode[3] && channel_match_irq[3]);
endmodule : etcc_timer

// >>> verif/etcc_pins.sv
// pin model for the event, clear and capture inputs of the timer
`timescale 1ns/10ps
module etcc_pins (
    input  wire logic core_clk,
    output logic      event_count_input,
    output logic      external_clear_input,
    output logic [3:0] capture_trigger_input
);
    // pins idle low until routed and started
    initial
    begin
        event_count_input = 1'b0;
        external_clear_input = 1'b0;
        capture_trigger_input = 4'h0;
    end
    // each level stands four cycles, above one edge per two
    task automatic hold4();
        repeat (4) @(posedge core_clk);
    endtask : hold4
    task automatic pulse_event(input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            event_count_input <= 1'b1;
            hold4();
            event_count_input <= 1'b0;
            hold4();
        end
    endtask : pulse_event
    // fast run: one level a cycle, counted in both-edge mode
    task automatic toggle_event(input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            event_count_input <= ~event_count_input;
        end
        hold4();
    endtask : toggle_event
    task automatic pulse_clear();
        @(posedge core_clk);
        external_clear_input <= 1'b1;
        hold4();
        external_clear_input <= 1'b0;
        hold4();
    endtask : pulse_clear
    task automatic set_capture(input logic [3:0] v);
        @(posedge core_clk);
        capture_trigger_input <= v;
        hold4();
        hold4();
    endtask : set_capture
endmodule : etcc_pins

// >>> verif/etcc_timer_test.sv
// self-checking bench for the event timer with capture/compare channels
`timescale 1ns/10ps
module etcc_timer_test;
    logic        core_clk;
    logic        rst_b;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire  logic  hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        event_count_input;
    logic        external_clear_input;
    logic [3:0]  capture_trigger_input;
    logic        overflow_irq;
    logic [3:0]  channel_match_irq;
    logic        pulse_out_a;
    logic        pulse_out_b;
    int          n_errors;
    int          checks_done;
    int          irq_n [4];
    int          ov_n;

    assign hready = hreadyout;
    etcc_timer i_dut (
        .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .event_count_input(event_count_input),
        .external_clear_input(external_clear_input),
        .capture_trigger_input(capture_trigger_input),
        .overflow_irq(overflow_irq), .channel_match_irq(channel_match_irq),
        .pulse_out_a(pulse_out_a), .pulse_out_b(pulse_out_b)
    );
    etcc_pins i_pins (
        .core_clk(core_clk), .event_count_input(event_count_input),
        .external_clear_input(external_clear_input),
        .capture_trigger_input(capture_trigger_input)
    );
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(negedge core_clk)
    begin
        for (int i = 0; i < 4; i++)
            if (channel_match_irq[i] === 1'b1) irq_n[i]++;
        if (overflow_irq === 1'b1) ov_n++;
    end
    // ----------
    // bus and check tasks
    // ----------
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_rdy();
        int n;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1)
        begin
            chk("hready", 32'h1, 32'(hready));
            conclude();
        end
    endtask : wait_rdy
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       input logic [2:0] sz, output logic [31:0] rdv);
        haddr <= {24'h0, a};
        htrans <= etcc_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= sz;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rdv = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        bus(1'b1, a, v, 3'h2, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        bus(1'b0, a, 32'h0, 3'h2, v);
    endtask : rd
    // ----------
    // scenarios
    // ----------
    task automatic t_reset();
        logic [31:0] d;
        rd(etcc_pkg::OFS_CTRL, d);
        chk("ctrl reset", {27'h0, etcc_pkg::CTRL_RESET}, d);
        rd(etcc_pkg::OFS_MODE, d);
        chk("mode reset", {16'h0, etcc_pkg::MODE_RESET}, d);
        rd(etcc_pkg::OFS_EDGE, d);
        chk("edge reset", {24'h0, etcc_pkg::EDGE_RESET}, d);
        rd(8'h20, d);
        chk("unmapped", 32'h0, d);
        chk("response", 32'h0, 32'(hresp));
    endtask : t_reset
    task automatic t_event();
        logic [31:0] d;
        logic [31:0] n;
        n = 32'h0;
        for (int e = 0; e < 4; e++)
        begin
            wr(etcc_pkg::OFS_CTRL, 32'h0);
            wr(etcc_pkg::OFS_MODE, 32'(e << 10));
            wr(etcc_pkg::OFS_CTRL, 32'h3);
            i_pins.pulse_event(2);
            n = n + 32'((e == 2) ? 0 : (e == 3) ? 4 : 2);
            rd(etcc_pkg::OFS_COUNT, d);
            chk("event count", n, d);
        end
        wr(etcc_pkg::OFS_CTRL, 32'h0);
        i_pins.pulse_event(2);
        rd(etcc_pkg::OFS_COUNT, d);
        chk("stopped count", n, d);
        bus(1'b0, etcc_pkg::OFS_COUNT, 32'h0, 3'h0, d);
        chk("byte read", 32'h0, d);
        wr(etcc_pkg::OFS_COUNT, 32'h5555);
        rd(etcc_pkg::OFS_COUNT, d);
        chk("count read only", n, d);
    endtask : t_event
    task automatic t_rates();
        logic [31:0] a;
        logic [31:0] b;
        int          div;
        for (int p2 = 0; p2 < 3; p2++)
            for (int p1 = 0; p1 < 2; p1++)
            begin
                div = 2 << (p1 + 2 * p2);
                wr(etcc_pkg::OFS_CTRL, 32'h0);
                wr(etcc_pkg::OFS_CTRL, 32'((p2 << 3) | (p1 << 2) | 1));
                repeat (2 * div) @(posedge core_clk);
                rd(etcc_pkg::OFS_COUNT, a);
                repeat (8 * div - 2) @(posedge core_clk);
                rd(etcc_pkg::OFS_COUNT, b);
                chk("count steps", 32'h8, (b - a) & 32'hffff);
            end
    endtask : t_rates
    task automatic t_clear();
        logic [31:0] v [3];
        logic [31:0] d;
        wr(etcc_pkg::OFS_CTRL, 32'h0);
        wr(etcc_pkg::OFS_MODE, 32'h1100);
        wr(etcc_pkg::OFS_CTRL, 32'h08);
        for (int t = 0; t < 3; t++)
        begin
            repeat (t + 1) @(posedge core_clk);
            i_pins.pulse_clear();
            repeat (20) @(posedge core_clk);
            rd(etcc_pkg::OFS_COUNT, v[t]);
            if (t > 0) chk("count after clear", v[0], v[t]);
        end
        chk("restart", 32'h1, 32'(v[0] != 0 && v[0] < 8));
        rd(etcc_pkg::OFS_CTRL, d);
        chk("enable after clear", 32'h1, d & 32'h1);
    endtask : t_clear
    task automatic t_capture();
        logic [31:0] c;
        logic [31:0] d;
        int          s [4];
        int          xr [4] = '{1, 0, 1, 0};
        int          xf [4] = '{0, 1, 1, 0};
        wr(etcc_pkg::OFS_CTRL, 32'h0);
        wr(etcc_pkg::OFS_MODE, 32'h0a00);
        wr(etcc_pkg::OFS_EDGE, 32'hb1);
        for (int i = 0; i < 4; i++) wr(etcc_pkg::OFS_CC0 + 8'(4 * i), 32'h1230 + i);
        rd(etcc_pkg::OFS_COUNT, c);
        for (int ph = 0; ph < 2; ph++)
        begin
            s = irq_n;
            i_pins.set_capture(ph == 0 ? 4'hf : 4'h0);
            for (int i = 0; i < 4; i++)
                chk("capture irq", ph == 0 ? xr[i] : xf[i], irq_n[i] - s[i]);
        end
        for (int i = 0; i < 4; i++)
        begin
            rd(etcc_pkg::OFS_CC0 + 8'(4 * i), d);
            chk("captured", (i == 3) ? 32'h1233 : c, d);
        end
    endtask : t_capture
    task automatic t_compare();
        logic [31:0] c;
        int          off [4] = '{2, 4, 3, 5};
        int          s [4];
        wr(etcc_pkg::OFS_CTRL, 32'h0);
        wr(etcc_pkg::OFS_MODE, 32'h04f8);
        wr(etcc_pkg::OFS_CTRL, 32'h3);
        rd(etcc_pkg::OFS_COUNT, c);
        for (int i = 0; i < 4; i++) wr(etcc_pkg::OFS_CC0 + 8'(4 * i), c + off[i]);
        for (int k = 1; k < 7; k++)
        begin
            s = irq_n;
            i_pins.pulse_event(1);
            chk("pulse a", 32'(k >= 2 && k < 4), 32'(pulse_out_a));
            chk("pulse b", 32'(k >= 3 && k < 5), 32'(pulse_out_b));
            for (int i = 0; i < 4; i++)
                chk("match irq", 32'(k == off[i] && i != 3), irq_n[i] - s[i]);
        end
        wr(etcc_pkg::OFS_EDGE, 32'h40);
        s = irq_n;
        i_pins.set_capture(4'h8);
        chk("pin irq", 32'h1, irq_n[3] - s[3]);
        i_pins.set_capture(4'h0);
    endtask : t_compare
    task automatic t_overflow();
        logic [31:0] d;
        int          s;
        int          n;
        wr(etcc_pkg::OFS_CTRL, 32'h0);
        wr(etcc_pkg::OFS_MODE, 32'h2c00);
        wr(etcc_pkg::OFS_CTRL, 32'h3);
        rd(etcc_pkg::OFS_COUNT, d);
        s = ov_n;
        i_pins.toggle_event(32'h10000 - (d & 32'hffff) + 8);
        for (n = 0; n < 8 && ov_n == s; n++) @(posedge core_clk);
        chk("overflow irq", 32'h1, ov_n - s);
        if (ov_n == s) conclude();
        rd(etcc_pkg::OFS_COUNT, d);
        chk("count at stop", 32'h0, d);
        i_pins.toggle_event(6);
        rd(etcc_pkg::OFS_COUNT, d);
        chk("count held", 32'h0, d);
        rd(etcc_pkg::OFS_CTRL, d);
        chk("enable kept", 32'h1, d & 32'h1);
        wr(etcc_pkg::OFS_CTRL, 32'h3);
        i_pins.toggle_event(4);
        rd(etcc_pkg::OFS_COUNT, d);
        chk("resumed", 32'h4, d);
    endtask : t_overflow
    // ----------
    // main sequence
    // ----------
    initial
    begin
        rst_b = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_event();
        t_rates();
        t_clear();
        t_capture();
        t_compare();
        t_overflow();
        conclude();
    end
endmodule : etcc_timer_test
